// file: verilog/lmtc_pkg.sv
// Constants, types and helpers for the LED mode and trigger control block
package lmtc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_FLASH_TIMER = 8'h05;
  localparam logic [7:0] ADDR_CTRL        = 8'h06;
  localparam logic [7:0] ADDR_TRIG        = 8'h07;

  // ==========================================================================
  // Field positions and reset values
  localparam int         CTRL_MODE_LSB    = 0;
  localparam int         CTRL_MODE_MSB    = 1;
  localparam int         CTRL_OUT_ON_BIT  = 3;
  localparam int         TRIG_TYPE_BIT    = 6;
  localparam int         TRIG_EN_BIT      = 7;
  localparam logic [7:0] FLASH_TIMER_RST  = 8'h23;
  localparam logic [7:0] TRIG_CFG_RST     = 8'hC0;
  localparam logic [1:0] EXT_TORCH_SEL_ON = 2'h2;
  localparam logic [7:0] FLASH_FINE_MAX   = 8'h7F;
  localparam logic [9:0] FLASH_COARSE_OFS = 10'h17C;
  localparam logic [9:0] UNIT_ONE         = 10'h001;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
  localparam int unsigned PWM_FREQ_HZ    = 31_250;
  localparam int unsigned PWM_STEPS      = 16;
  localparam int unsigned PWM_PERIOD_CYC = CLK_FREQ_HZ / PWM_FREQ_HZ;
  localparam int unsigned PWM_STEP_CYC   = PWM_PERIOD_CYC / PWM_STEPS;
  localparam int unsigned FLASH_STEP_MS  = 2;
  localparam int unsigned FLASH_TICK_CYC = CLK_FREQ_HZ / 1000 * FLASH_STEP_MS;
  localparam logic [8:0]  PWM_STEP_LAST  = 9'(PWM_STEP_CYC - 1);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_IND    = 2'h1,
    MODE_ASSIST = 2'h2,
    MODE_FLASH  = 2'h3
  } lmtc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARMED = 2'h1,
    ST_FLASH = 2'h3,
    ST_DONE  = 2'h2
  } lmtc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmtc_reg_req_t;

  typedef struct packed {
    logic       enable;
    logic [7:0] current;
  } lmtc_sink_t;

  // Duration code to count of 2 ms units: fine steps, then 8 ms steps
  function automatic logic [9:0] lmtc_flash_units(input logic [7:0] code);
    if (code <= FLASH_FINE_MAX) begin
      return {2'h0, code} + UNIT_ONE;
    end
    return {code, 2'h0} - FLASH_COARSE_OFS;
  endfunction

endpackage

// file: verilog/lmtc_flash_timer.sv
// Flash duration and timeout timer counting in 2 ms units
`timescale 1ns/1ns
module lmtc_flash_timer #(
  parameter int unsigned TICK_CYC = lmtc_pkg::FLASH_TICK_CYC
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [9:0] units,
  output logic            expired
);
  import lmtc_pkg::*;

  localparam logic [19:0] TICK_LAST = 20'(TICK_CYC - 1);

  logic [19:0] tick_reg;
  logic [9:0]  remain_reg;
  logic        run_reg;

  // ==========================================================================
  // Countdown
  always_ff @(posedge mclk) begin
    if (srst || stop) begin
      run_reg    <= 1'b0;
      remain_reg <= '0;
      tick_reg   <= '0;
    end else if (start) begin
      run_reg    <= 1'b1;
      remain_reg <= units;
      tick_reg   <= '0;
    end else if (run_reg) begin
      if (tick_reg == TICK_LAST) begin
        tick_reg   <= '0;
        remain_reg <= remain_reg - UNIT_ONE;
        if (remain_reg == UNIT_ONE) begin
          run_reg <= 1'b0;
        end
      end else begin
        tick_reg <= tick_reg + 20'h0_0001;
      end
    end
  end

  // High in the last counted cycle; a register here would add one cycle
  assign expired = run_reg && !srst && !stop && (tick_reg == TICK_LAST) &&
                   (remain_reg == UNIT_ONE);

endmodule // lmtc_flash_timer

// file: verilog/lmtc_ctrl.sv
// Operating mode, sink enable and flash trigger control of an LED driver
// Summary of operation
// R1: Mode 00 keeps sinks off, unless external torch select is 10.
// R2: Mode 01 uses six low current bits, PWM at 31.25 kHz by duty.
// R3: Mode 10 uses seven low current bits, top bit ignored.
// R4: Hence largest assist current is half the largest flash current.
// R5: Mode 11 uses the full current code during the flash pulse.
// R6: After a flash pulse, sink enable and mode clear to 00.
// R7: Sink enable bit 3 resets to 0; 0 disables, 1 enables sinks.
// R8: Host writes 0 to reserved control bit 2, ignores its read.
// R9: Trigger type bit 6 resets to 1; 0 edge, 1 level sensitive.
// R10: Trigger enable bit 7 resets to 1; 0 ignores trigger input.
// R11: Mode field is control register bits 1:0, address 6, reset 00.
// R12: Host clears mode, sink enable, torch select before fixed voltage.
// R13: Duration code: 2 ms steps to 7F, 8 ms beyond, reset 23h.
// R14: Level trigger holds flash up to timeout; edge starts one timed flash.
`timescale 1ns/1ns
module lmtc_ctrl #(
  parameter int unsigned TICK_CYC = lmtc_pkg::FLASH_TICK_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire lmtc_pkg::lmtc_reg_req_t reg_req,
  output logic [7:0]                  reg_rdata,
  input  wire logic [7:0]             led_current,
  input  wire logic [3:0]             ind_duty,
  input  wire logic [1:0]             ext_torch_sel,
  input  wire logic                   flash_trigger,
  output lmtc_pkg::lmtc_sink_t        current_sink_pins,
  output logic                        flash_active,
  output logic                        flash_timed_out
);
  import lmtc_pkg::*;

  lmtc_mode_t  mode_reg;
  logic        out_on_reg;
  logic [7:0]  flash_timer_reg;
  logic [7:0]  trig_cfg_reg;
  lmtc_state_t state_reg;
  lmtc_state_t state_next;
  logic        trig_d_reg;
  logic [8:0]  pwm_step_reg;
  logic [3:0]  pwm_phase_reg;
  lmtc_sink_t  sink_next;
  logic        ctrl_wr;
  logic        trig_en;
  logic        trig_level;
  logic        trig_rise;
  logic        flash_cmd;
  logic        go;
  logic        timer_start;
  logic        timer_stop;
  logic        expired;
  logic        pwm_high;

  assign ctrl_wr    = reg_req.wr && (reg_req.addr == ADDR_CTRL);
  assign trig_en    = trig_cfg_reg[TRIG_EN_BIT];
  assign trig_level = trig_cfg_reg[TRIG_TYPE_BIT];
  assign trig_rise  = flash_trigger && !trig_d_reg;
  assign flash_cmd  = (mode_reg == MODE_FLASH) && out_on_reg;

  // ==========================================================================
  // Control register: host write wins over the end-of-flash clear so that a
  // fresh command written in that cycle is never lost
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_reg   <= MODE_OFF;                                    // [R11]
      out_on_reg <= 1'b0;                                        // [R7]
    end else if (ctrl_wr) begin
      mode_reg   <= lmtc_mode_t'(reg_req.wdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
      out_on_reg <= reg_req.wdata[CTRL_OUT_ON_BIT];
    end else if (state_reg == ST_DONE) begin
      mode_reg   <= MODE_OFF;                                    // [R6]
      out_on_reg <= 1'b0;                                        // [R6]
    end
  end

  // ==========================================================================
  // Flash timer and trigger configuration registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      flash_timer_reg <= FLASH_TIMER_RST;                        // [R13]
    end else if (reg_req.wr && (reg_req.addr == ADDR_FLASH_TIMER)) begin
      flash_timer_reg <= reg_req.wdata;
    end
  end

  // Bits 5:0 belong to current reduction elsewhere; kept as plain storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      trig_cfg_reg <= TRIG_CFG_RST;                              // [R9] [R10]
    end else if (reg_req.wr && (reg_req.addr == ADDR_TRIG)) begin
      trig_cfg_reg <= reg_req.wdata;
    end
  end

  // ==========================================================================
  // Read port; reserved bit 2 and unmapped addresses read as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_FLASH_TIMER: reg_rdata <= flash_timer_reg;
        ADDR_CTRL: begin
          reg_rdata <= '0;                                       // [R8]
          reg_rdata[CTRL_OUT_ON_BIT] <= out_on_reg;
          reg_rdata[CTRL_MODE_MSB:CTRL_MODE_LSB] <= mode_reg;
        end
        ADDR_TRIG:        reg_rdata <= trig_cfg_reg;
        default:          reg_rdata <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Trigger edge detect; the pin is taken as synchronous to mclk
  always_ff @(posedge mclk) begin
    if (srst) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= flash_trigger;
    end
  end

  // ==========================================================================
  // Flash sequencer
  always_comb begin
    go = 1'b0;
    if (!trig_en) begin
      go = 1'b1;                                                 // [R10]
    end else if (trig_level) begin
      go = flash_trigger;                                        // [R9] [R14]
    end else begin
      go = trig_rise;                                            // [R9] [R14]
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (flash_cmd) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!flash_cmd) begin
          state_next = ST_IDLE;
        end else if (go) begin
          state_next = ST_FLASH;
        end
      end
      ST_FLASH: begin
        if (!flash_cmd) begin
          state_next = ST_IDLE;
        end else if (expired) begin
          state_next = ST_DONE;                                  // [R14]
        end else if (trig_en && trig_level && !flash_trigger) begin
          state_next = ST_DONE;                                  // [R14]
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign timer_start = (state_reg == ST_ARMED) && (state_next == ST_FLASH);
  assign timer_stop  = (state_reg != ST_FLASH) && !timer_start;

  lmtc_flash_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .mclk    (mclk),
    .srst    (srst),
    .start   (timer_start),
    .stop    (timer_stop),
    .units   (lmtc_flash_units(flash_timer_reg)),                // [R13]
    .expired (expired)
  );

  // Level mode ends on the timer only when the trigger outstays it
  always_ff @(posedge mclk) begin
    if (srst) begin
      flash_timed_out <= 1'b0;
      flash_active    <= 1'b0;
    end else begin
      flash_timed_out <= expired && trig_en && trig_level;       // [R14]
      flash_active    <= (state_next == ST_FLASH);
    end
  end

  // ==========================================================================
  // Indicator PWM: 16 duty steps within one 31.25 kHz period
  always_ff @(posedge mclk) begin
    if (srst) begin
      pwm_step_reg  <= '0;
      pwm_phase_reg <= '0;
    end else if (pwm_step_reg == PWM_STEP_LAST) begin
      pwm_step_reg  <= '0;
      pwm_phase_reg <= pwm_phase_reg + 4'h1;                     // [R2]
    end else begin
      pwm_step_reg  <= pwm_step_reg + 9'h001;
    end
  end

  assign pwm_high = (pwm_phase_reg <= ind_duty);                 // [R2]

  // ==========================================================================
  // Sink drive
  always_comb begin
    sink_next = '0;
    case (mode_reg)
      MODE_OFF: begin
        sink_next.enable  = (ext_torch_sel == EXT_TORCH_SEL_ON); // [R1]
        sink_next.current = {1'b0, led_current[6:0]};
      end
      MODE_IND: begin
        sink_next.enable  = out_on_reg && pwm_high;              // [R2] [R7]
        sink_next.current = {2'h0, led_current[5:0]};            // [R2]
      end
      MODE_ASSIST: begin
        sink_next.enable  = out_on_reg;                          // [R7]
        sink_next.current = {1'b0, led_current[6:0]};            // [R3] [R4]
      end
      MODE_FLASH: begin
        sink_next.enable  = out_on_reg && (state_reg == ST_FLASH);
        sink_next.current = led_current;                         // [R5]
      end
      default: sink_next = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      current_sink_pins <= '0;
    end else begin
      current_sink_pins <= sink_next;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_level_flash;
    state_reg == ST_FLASH && trig_en && trig_level && flash_cmd;
  endsequence

  sequence s_release;
    !flash_trigger && !expired;
  endsequence

  a_flash_clear_mode: assert property ( // [R6]
    (state_reg == ST_DONE && !ctrl_wr) |=> (mode_reg == MODE_OFF && !out_on_reg))
    else $error("mode or sink enable not cleared after flash");

  a_shutdown_off: assert property ( // [R1]
    (mode_reg == MODE_OFF && ext_torch_sel != EXT_TORCH_SEL_ON)
      |=> !current_sink_pins.enable)
    else $error("sinks driven in shutdown");

  a_ext_torch_on: assert property ( // [R1]
    (mode_reg == MODE_OFF && ext_torch_sel == EXT_TORCH_SEL_ON)
      |=> current_sink_pins.enable)
    else $error("external torch not driven");

  a_ind_current: assert property ( // [R2]
    (mode_reg == MODE_IND)
      |=> current_sink_pins.current == {2'h0, $past(led_current[5:0])})
    else $error("indicator current code wrong");

  a_assist_half: assert property ( // [R3]
    (mode_reg == MODE_ASSIST) |=> (current_sink_pins.current[7] == 1'b0 &&
      current_sink_pins.current[6:0] == $past(led_current[6:0])))
    else $error("assist current uses top bit");

  a_flash_current: assert property ( // [R5]
    (state_reg == ST_FLASH && flash_cmd)
      |=> current_sink_pins.current == $past(led_current))
    else $error("flash current code wrong");

  a_out_off_sinks: assert property ( // [R7]
    (!out_on_reg && mode_reg != MODE_OFF) |=> !current_sink_pins.enable)
    else $error("sinks on with sink enable clear");

  a_trig_disabled: assert property ( // [R10]
    (state_reg == ST_ARMED && flash_cmd && !trig_en) |=> state_reg == ST_FLASH)
    else $error("flash not started with trigger disabled");

  a_edge_start: assert property ( // [R9]
    (state_reg == ST_ARMED && flash_cmd && trig_en && !trig_level &&
      !trig_rise) |=> state_reg != ST_FLASH)
    else $error("edge trigger started flash without a rising edge");

  a_level_release: assert property ( // [R14]
    s_level_flash ##0 s_release |=> state_reg == ST_DONE ##1 !out_on_reg)
    else $error("level flash not ended on trigger release");

  a_reset_values: assert property ( // [R11]
    $fell(srst) |-> (mode_reg == MODE_OFF && !out_on_reg &&
      flash_timer_reg == FLASH_TIMER_RST && trig_cfg_reg == TRIG_CFG_RST))
    else $error("register reset values wrong");

endmodule // lmtc_ctrl

// file: bench/lmtc_host_model.sv
// Host model: register strobes and flash trigger of the camera processor
`timescale 1ns/1ns
module lmtc_host_model (
  input  wire logic           mclk,
  input  wire logic [7:0]     reg_rdata,
  output lmtc_pkg::lmtc_reg_req_t reg_req,
  output logic                flash_trigger
);
  import lmtc_pkg::*;

  initial begin
    reg_req       = '0;
    flash_trigger = 1'b0;
  end

  // ==========================================================================
  // Bus cycles
  // Clears reserved control bit 2 on control writes, never enters fixed voltage mode
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_req.wr    = 1'b1;
    reg_req.addr  = a;
    reg_req.wdata = (a == ADDR_CTRL) ? (d & 8'hFB) : d;
    @(posedge mclk);
    #1;
    reg_req.wr    = 1'b0;
    // Released lines flip so no stale value looks valid
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_req.rd   = 1'b1;
    reg_req.addr = a;
    @(posedge mclk);
    #1;
    // Data registered at the edge that took the strobe
    d = reg_rdata;
    reg_req.rd   = 1'b0;
    reg_req.addr = ~reg_req.addr;
  endtask

  task automatic set_trigger(input logic v);
    @(posedge mclk);
    #1;
    flash_trigger = v;
  endtask
endmodule // lmtc_host_model

// file: bench/lmtc_ctrl_bench.sv
// Self-checking bench of the LED mode and trigger control block
`timescale 1ns/1ns
module lmtc_ctrl_bench;
  import lmtc_pkg::*;
  // Short tick keeps flash runs to a few thousand cycles
  localparam int unsigned TICK = 20;

  logic          mclk;
  logic          srst;
  lmtc_reg_req_t reg_req;
  logic [7:0]    reg_rdata;
  logic [7:0]    led_current;
  logic [3:0]    ind_duty;
  logic [1:0]    ext_torch_sel;
  logic          flash_trigger;
  lmtc_sink_t    sink;
  logic          flash_active;
  logic          flash_timed_out;
  int            err_total;
  int            comparisons;

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  lmtc_ctrl #(.TICK_CYC(TICK)) uut (
    .mclk              (mclk),
    .srst              (srst),
    .reg_req           (reg_req),
    .reg_rdata         (reg_rdata),
    .led_current       (led_current),
    .ind_duty          (ind_duty),
    .ext_torch_sel     (ext_torch_sel),
    .flash_trigger     (flash_trigger),
    .current_sink_pins (sink),
    .flash_active      (flash_active),
    .flash_timed_out   (flash_timed_out)
  );

  lmtc_host_model host (
    .mclk          (mclk),
    .reg_rdata     (reg_rdata),
    .reg_req       (reg_req),
    .flash_trigger (flash_trigger)
  );

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic run_flash(output int len, output logic to,
                           output logic [7:0] cur);
    int guard;
    len = 0;
    to = 1'b0;
    cur = 8'h00;
    guard = 0;
    while (flash_active !== 1'b1 && guard < 100) begin
      step(1);
      guard++;
    end
    while (flash_active === 1'b1 && len < 4000) begin
      step(1);
      len++;
      if (len == 3) cur = sink.current;
      if (flash_timed_out === 1'b1) to = 1'b1;
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    host.read_reg(ADDR_CTRL, d);
    check("ctrl reset", 8'h00, d);
    host.read_reg(ADDR_TRIG, d);
    check("trig reset", 8'hC0, d);
    host.read_reg(ADDR_FLASH_TIMER, d);
    check("timer reset", 8'h23, d);
    host.read_reg(8'h2A, d);
    check("unmapped read", 8'h00, d);
    check("sinks reset", 1'b0, sink.enable);
  endtask

  task automatic t_modes();
    logic [7:0] d;
    logic [7:0] cur;
    int         high;
    led_current = 8'hFF;
    host.write_reg(ADDR_CTRL, 8'h0A);
    host.read_reg(ADDR_CTRL, d);
    check("ctrl readback", 8'h0A, d);
    check("assist enable", 1'b1, sink.enable);
    check("assist current", 8'h7F, sink.current);
    host.write_reg(ADDR_CTRL, 8'h02);
    step(3);
    check("out_on clear", 1'b0, sink.enable);
    host.write_reg(ADDR_CTRL, 8'h09);
    // Duty n gives n+1 of 16 steps of 500 cycles
    for (int k = 0; k < 2; k++) begin
      ind_duty = k ? 4'h0 : 4'h3;
      led_current = k ? 8'hD9 : 8'hFF;
      step(10);
      high = 0;
      cur = 8'h00;
      // One full PWM period: 250 MHz over 31.25 kHz
      repeat (8000) begin
        step(1);
        if (sink.enable === 1'b1) begin
          high++;
          cur = sink.current;
        end
      end
      check("pwm on cycles", k ? 16'h01F4 : 16'h07D0, 16'(high));
      check("pwm current", k ? 8'h19 : 8'h3F, cur);
    end
    host.write_reg(ADDR_CTRL, 8'h00);
    ext_torch_sel = 2'h2;
    step(3);
    check("torch enable", 1'b1, sink.enable);
    ext_torch_sel = 2'h3;
    step(3);
    check("torch other code", 1'b0, sink.enable);
    ext_torch_sel = 2'h0;
    step(3);
    check("shutdown", 1'b0, sink.enable);
  endtask

  task automatic t_flash_timed();
    logic [7:0]  codes [3] = '{8'h01, 8'h7F, 8'h80};
    int unsigned units [3] = '{2, 128, 132};
    int          len;
    logic        to;
    logic [7:0]  cur;
    logic [7:0]  d;
    host.write_reg(ADDR_TRIG, 8'h00);
    led_current = 8'hA5;
    foreach (codes[i]) begin
      host.write_reg(ADDR_FLASH_TIMER, codes[i]);
      host.write_reg(ADDR_CTRL, 8'h0B);
      run_flash(len, to, cur);
      check("flash length", 16'(units[i] * TICK), 16'(len));
      check("flash current", 8'hA5, cur);
      check("no timeout pulse", 1'b0, to);
      step(3);
      host.read_reg(ADDR_CTRL, d);
      check("auto clear", 8'h00, d);
      check("sinks after", 1'b0, sink.enable);
    end
  endtask

  task automatic t_triggers();
    int         len;
    logic       to;
    logic [7:0] cur;
    logic [7:0] d;
    host.write_reg(ADDR_FLASH_TIMER, 8'h01);
    host.write_reg(ADDR_TRIG, 8'hC0);
    host.write_reg(ADDR_CTRL, 8'h0B);
    step(10);
    check("level waits", 1'b0, flash_active);
    host.set_trigger(1'b1);
    run_flash(len, to, cur);
    check("level timeout", 16'(2 * TICK), 16'(len));
    check("timeout pulse", 1'b1, to);
    host.set_trigger(1'b0);
    host.write_reg(ADDR_CTRL, 8'h0B);
    step(5);
    host.set_trigger(1'b1);
    step(10);
    check("level held", 1'b1, flash_active);
    host.set_trigger(1'b0);
    step(6);
    check("level release", 1'b0, flash_active);
    host.read_reg(ADDR_CTRL, d);
    check("level clear", 8'h00, d);
    host.write_reg(ADDR_TRIG, 8'h80);
    host.set_trigger(1'b1);
    host.write_reg(ADDR_CTRL, 8'h0B);
    step(10);
    check("edge needs rise", 1'b0, flash_active);
    host.set_trigger(1'b0);
    host.set_trigger(1'b1);
    host.set_trigger(1'b0);
    run_flash(len, to, cur);
    check("edge length", 16'(2 * TICK), 16'(len));
    check("edge no timeout", 1'b0, to);
    host.read_reg(ADDR_CTRL, d);
    check("edge clear", 8'h00, d);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    srst = 1'b1;
    led_current = 8'h00;
    ind_duty = 4'h0;
    ext_torch_sel = 2'h0;
    err_total = 0;
    comparisons = 0;
    repeat (16) @(posedge mclk);
    #1;
    srst = 1'b0;
    t_reset();
    t_modes();
    t_flash_timed();
    t_triggers();
    summarize();
  end

  // Whole run needs about 22000 cycles; this allows over twice that
  initial begin
    #200000;
    err_total++;
    summarize();
  end
endmodule // lmtc_ctrl_bench
